// [shared/chan_cfg_regs.vh]
/*
 * register addresses, field positions and timing constants of the read channel
 * configuration bank. assumes a 250 MHz core clock.
 */
`ifndef CHAN_CFG_REGS_VH
`define CHAN_CFG_REGS_VH
`define ADDR_POWER_DOWN 8'h04
`define ADDR_DATA_CUTOFF 8'h14
`define ADDR_SERVO_CUTOFF 8'h24
`define ADDR_DATA_BOOST 8'h34
`define ADDR_SERVO_BOOST_GD 8'h44
`define ADDR_VITERBI_TARGETS 8'h54
`define ADDR_DATA_LEVEL 8'h64
`define ADDR_SERVO_LEVEL 8'h74
`define ADDR_TEST_MODE_ONE 8'h84
`define ADDR_TEST_MODE_TWO 8'h94
`define ADDR_TIMEBASE_N 8'ha4
`define ADDR_TIMEBASE_M 8'hb4
`define ADDR_DATA_RATE 8'hc4
`define ADDR_WRITE_PRECOMP 8'hd4
`define ADDR_SAMPLE_LOOP 8'he4
`define NUM_REGS 15
`define REG_RESET 8'h00
`define BIT_FRONT_SLEEP 0
`define BIT_SEPARATOR_SLEEP 1
`define BIT_TIMEBASE_SLEEP 2
`define BIT_COUPLER_HOLD 3
`define BIT_PROBE_ENABLE 7
`define BIT_SERVO_CAL 7
`define BIT_ASPERITY_EN 7
`define BIT_GD_SIGN 5
`define BIT_DEFECT_SCAN 7
`define BIT_AGC_HOLD 6
`define BIT_SAMPLE_SRC 7
`define BIT_BYPASS 2
`define BIT_RESYNC 3
`define BIT_DUAL_MATCH 2
`define BIT_PRESCALE 7
`define BIT_SCAN_START 7
`define SFC_STEP 8'h10
`endif

// [rtl/read_channel_config_regs.v]
/*
 * serially programmed configuration register bank of a disk read channel,
 * with decode of the control fields into the datapath's control lines.
 * assumes: host drives serial_enable_pin, serial clock and data as pins
 * (synchronised here); msb-first frames of 8 address then 8 data bits,
 * rising serial clock samples data; address bit 0 set marks a read.
 * datapath status (vco lock, sync detect, parity, etc.) arrives on clk_i.
 */
`timescale 1ns/10ps
`include "chan_cfg_regs.vh"
module read_channel_config_regs (
	input wire clk_i,
	input wire reset_i,
	input wire serial_enable_pin_i,
	input wire serial_clock_i,
	input wire serial_data_i,
	output reg serial_data_o,
	output reg serial_data_oe_o,
	input wire read_gate_i,
	input wire write_gate_i,
	input wire vco_lock_indication_i,
	input wire sync_count_point_i,
	input wire byte_clock_en_i,
	input wire parity_i,
	input wire framing_detect_i,
	input wire error_flag_i,
	input wire dropout_i,
	input wire agc_timing_source_i,
	input wire hiy_dynamic_i,
	output reg timebase_sleep_o,
	output reg separator_sleep_o,
	output reg front_sleep_o,
	output reg [1:0] analog_probe_select_o,
	output reg coupler_sampled_o,
	output reg [1:0] tp_pair_select_o,
	output reg tp_third_enable_o,
	output reg tp_extra_enable_o,
	output reg tp_extra_code_o,
	output reg [6:0] data_cutoff_o,
	output reg [6:0] servo_cutoff_o,
	output reg servo_calibrate_o,
	output reg asperity_detect_enable_o,
	output reg [6:0] data_boost_o,
	output reg [1:0] servo_boost_o,
	output reg group_delay_sign_o,
	output reg [4:0] group_delay_mag_o,
	output reg [3:0] target_neg_o,
	output reg [3:0] target_pos_o,
	output reg [5:0] data_qual_level_o,
	output reg scan_slice_o,
	output reg defect_flag_pin_o,
	output reg precoder_zero_o,
	output reg agc_hold_o,
	output reg sample_clock_source_o,
	output reg [2:0] probe_mux_select_o,
	output reg survival_bypass_o,
	output reg precoder_bypass_o,
	output reg byte_clock_restart_o,
	output reg sync_need_both_o,
	output reg parity_monitor_pin_o,
	output reg ref_prescale_o,
	output reg second_nrz_line_o,
	output reg [7:0] sync_field_count_o,
	output reg [6:0] timebase_n_o,
	output reg [7:0] timebase_m_o,
	output reg [6:0] data_rate_o,
	output reg [7:0] write_precomp_o
);
	localparam [3:0] IDX_PD = 4'd0;
	localparam [3:0] IDX_FC = 4'd1;
	localparam [3:0] IDX_FCS = 4'd2;
	localparam [3:0] IDX_FB = 4'd3;
	localparam [3:0] IDX_FBS = 4'd4;
	localparam [3:0] IDX_VT = 4'd5;
	localparam [3:0] IDX_LD = 4'd6;
	localparam [3:0] IDX_LDS = 4'd7;
	localparam [3:0] IDX_TM1 = 4'd8;
	localparam [3:0] IDX_TM2 = 4'd9;
	localparam [3:0] IDX_N = 4'd10;
	localparam [3:0] IDX_M = 4'd11;
	localparam [3:0] IDX_DR = 4'd12;
	localparam [3:0] IDX_WP = 4'd13;
	localparam [3:0] IDX_SLC = 4'd14;
	localparam [3:0] IDX_NONE = 4'd15;

	reg [2:0] sen_q, sck_q;
	reg [1:0] sdi_q;
	reg [7:0] bank_q [0:`NUM_REGS-1];
	reg [7:0] pd_live_q;
	reg [15:0] shift_q;
	reg [4:0] count_q;
	reg [7:0] rd_shift_q;
	reg rg_q, wg_q, scan_mark_q, scan_done_q, hold_q;
	reg [3:0] idx;
	integer k;

	// synchronised pins; stage 0 feeds only stage 1
	wire sen_s = sen_q[1];
	wire sck_rise = sck_q[1] & ~sck_q[2];
	wire sck_fall = ~sck_q[1] & sck_q[2];
	wire sen_fall = ~sen_q[1] & sen_q[2];
	wire rg_rise = read_gate_i & ~rg_q;
	wire wg_rise = write_gate_i & ~wg_q;
	wire rg_fall = ~read_gate_i & rg_q;

	// frame address as the last data bit arrives; bit 0 (read flag) dropped
	always @* begin
		case ({shift_q[14:8], 1'b0})
		`ADDR_POWER_DOWN: idx = IDX_PD;
		`ADDR_DATA_CUTOFF: idx = IDX_FC;
		`ADDR_SERVO_CUTOFF: idx = IDX_FCS;
		`ADDR_DATA_BOOST: idx = IDX_FB;
		`ADDR_SERVO_BOOST_GD: idx = IDX_FBS;
		`ADDR_VITERBI_TARGETS: idx = IDX_VT;
		`ADDR_DATA_LEVEL: idx = IDX_LD;
		`ADDR_SERVO_LEVEL: idx = IDX_LDS;
		`ADDR_TEST_MODE_ONE: idx = IDX_TM1;
		`ADDR_TEST_MODE_TWO: idx = IDX_TM2;
		`ADDR_TIMEBASE_N: idx = IDX_N;
		`ADDR_TIMEBASE_M: idx = IDX_M;
		`ADDR_DATA_RATE: idx = IDX_DR;
		`ADDR_WRITE_PRECOMP: idx = IDX_WP;
		`ADDR_SAMPLE_LOOP: idx = IDX_SLC;
		default: idx = IDX_NONE;
		endcase
	end

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			sen_q <= 3'b000;
			sck_q <= 3'b000;
			sdi_q <= 2'b00;
			shift_q <= 16'h0000;
			count_q <= 5'h00;
			rd_shift_q <= 8'h00;
			pd_live_q <= `REG_RESET;
			serial_data_o <= 1'b0;
			serial_data_oe_o <= 1'b0;
			for (k = 0; k < `NUM_REGS; k = k + 1)
				bank_q[k] <= `REG_RESET;
		end else begin
			sen_q <= {sen_q[1:0], serial_enable_pin_i};
			sck_q <= {sck_q[1:0], serial_clock_i};
			sdi_q <= {sdi_q[0], serial_data_i};
			if (!sen_s) begin
				count_q <= 5'h00;
				serial_data_oe_o <= 1'b0;
			end else if (sck_rise && count_q != 5'h10) begin
				shift_q <= {shift_q[14:0], sdi_q[1]};
				count_q <= count_q + 5'h01;
				if (count_q == 5'h07 && sdi_q[1]) begin
					// read frame: fetch addressed register for the data phase
					serial_data_oe_o <= 1'b1;
					case ({shift_q[6:0], 1'b0})
					`ADDR_POWER_DOWN: rd_shift_q <= bank_q[IDX_PD];
					`ADDR_DATA_CUTOFF: rd_shift_q <= bank_q[IDX_FC];
					`ADDR_SERVO_CUTOFF: rd_shift_q <= bank_q[IDX_FCS];
					`ADDR_DATA_BOOST: rd_shift_q <= bank_q[IDX_FB];
					`ADDR_SERVO_BOOST_GD: rd_shift_q <= bank_q[IDX_FBS];
					`ADDR_VITERBI_TARGETS: rd_shift_q <= bank_q[IDX_VT];
					`ADDR_DATA_LEVEL: rd_shift_q <= bank_q[IDX_LD];
					`ADDR_SERVO_LEVEL: rd_shift_q <= bank_q[IDX_LDS];
					`ADDR_TEST_MODE_ONE: rd_shift_q <= bank_q[IDX_TM1];
					`ADDR_TEST_MODE_TWO: rd_shift_q <= bank_q[IDX_TM2];
					`ADDR_TIMEBASE_N: rd_shift_q <= bank_q[IDX_N];
					`ADDR_TIMEBASE_M: rd_shift_q <= bank_q[IDX_M];
					`ADDR_DATA_RATE: rd_shift_q <= bank_q[IDX_DR];
					`ADDR_WRITE_PRECOMP: rd_shift_q <= bank_q[IDX_WP];
					`ADDR_SAMPLE_LOOP: rd_shift_q <= bank_q[IDX_SLC];
					default: rd_shift_q <= 8'h00;
					endcase
				end
				// whole byte kept, reserved bits included
				if (count_q == 5'h0f && !shift_q[7] && idx != IDX_NONE)
					bank_q[idx] <= {shift_q[6:0], sdi_q[1]};
			end else if (sck_fall && serial_data_oe_o) begin
				serial_data_o <= rd_shift_q[7];
				rd_shift_q <= {rd_shift_q[6:0], 1'b0};
			end
			// power-down sleep bits applied only at frame end
			if (sen_fall)
				pd_live_q <= bank_q[IDX_PD];
		end
	end

	wire [7:0] fc = bank_q[IDX_FC];
	wire [7:0] ldr = bank_q[IDX_LD];
	wire [7:0] tm1 = bank_q[IDX_TM1];
	wire [7:0] tm2 = bank_q[IDX_TM2];
	wire [7:0] dr = bank_q[IDX_DR];
	wire probe_en = fc[`BIT_PROBE_ENABLE];
	reg mon;
	always @* begin
		case (tm2[1:0])
		2'b00: mon = parity_i;
		2'b01: mon = framing_detect_i;
		2'b10: mon = vco_lock_indication_i;
		default: mon = error_flag_i;
		endcase
	end

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			{timebase_sleep_o, separator_sleep_o, front_sleep_o} <= 3'b000;
			analog_probe_select_o <= 2'b00;
			coupler_sampled_o <= 1'b0;
			tp_pair_select_o <= 2'b00;
			tp_third_enable_o <= 1'b0;
			tp_extra_enable_o <= 1'b0;
			tp_extra_code_o <= 1'b0;
			data_cutoff_o <= 7'h00;
			servo_cutoff_o <= 7'h00;
			servo_calibrate_o <= 1'b0;
			asperity_detect_enable_o <= 1'b0;
			data_boost_o <= 7'h00;
			servo_boost_o <= 2'b00;
			group_delay_sign_o <= 1'b0;
			group_delay_mag_o <= 5'h00;
			target_neg_o <= 4'h0;
			target_pos_o <= 4'h0;
			data_qual_level_o <= 6'h00;
			scan_slice_o <= 1'b0;
			defect_flag_pin_o <= 1'b0;
			precoder_zero_o <= 1'b0;
			agc_hold_o <= 1'b0;
			sample_clock_source_o <= 1'b0;
			probe_mux_select_o <= 3'b000;
			survival_bypass_o <= 1'b0;
			precoder_bypass_o <= 1'b0;
			byte_clock_restart_o <= 1'b0;
			sync_need_both_o <= 1'b0;
			parity_monitor_pin_o <= 1'b0;
			ref_prescale_o <= 1'b0;
			second_nrz_line_o <= 1'b0;
			sync_field_count_o <= `SFC_STEP;
			timebase_n_o <= 7'h00;
			timebase_m_o <= 8'h00;
			data_rate_o <= 7'h00;
			write_precomp_o <= 8'h00;
			rg_q <= 1'b0;
			wg_q <= 1'b0;
			scan_mark_q <= 1'b0;
			scan_done_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			rg_q <= read_gate_i;
			wg_q <= write_gate_i;
			timebase_sleep_o <= pd_live_q[`BIT_TIMEBASE_SLEEP];
			separator_sleep_o <= pd_live_q[`BIT_SEPARATOR_SLEEP];
			front_sleep_o <= pd_live_q[`BIT_FRONT_SLEEP];
			analog_probe_select_o <= bank_q[IDX_PD][5:4];
			coupler_sampled_o <= ~bank_q[IDX_PD][`BIT_COUPLER_HOLD] & vco_lock_indication_i;
			tp_pair_select_o <= probe_en ? bank_q[IDX_PD][7:6] : 2'b00;
			tp_third_enable_o <= probe_en && bank_q[IDX_PD][7:6] != 2'b00
				&& bank_q[IDX_PD][7:6] != 2'b11;
			tp_extra_enable_o <= probe_en && bank_q[IDX_PD][7:6] != 2'b00
				&& agc_timing_source_i && !hiy_dynamic_i;
			tp_extra_code_o <= bank_q[IDX_PD][7];
			data_cutoff_o <= fc[6:0];
			servo_cutoff_o <= bank_q[IDX_FCS][6:0];
			servo_calibrate_o <= bank_q[IDX_FCS][`BIT_SERVO_CAL];
			asperity_detect_enable_o <= bank_q[IDX_FB][`BIT_ASPERITY_EN];
			data_boost_o <= bank_q[IDX_FB][6:0];
			servo_boost_o <= bank_q[IDX_FBS][7:6];
			group_delay_sign_o <= bank_q[IDX_FBS][`BIT_GD_SIGN];
			group_delay_mag_o <= bank_q[IDX_FBS][4:0];
			target_neg_o <= bank_q[IDX_VT][7:4];
			target_pos_o <= bank_q[IDX_VT][3:0];
			data_qual_level_o <= ldr[5:0];
			scan_slice_o <= ldr[`BIT_DEFECT_SCAN] & read_gate_i;
			defect_flag_pin_o <= ldr[`BIT_DEFECT_SCAN] & read_gate_i & dropout_i;
			precoder_zero_o <= ldr[`BIT_DEFECT_SCAN] & write_gate_i;
			// hold from read gate fall to next count point
			if (rg_fall && ldr[`BIT_AGC_HOLD])
				hold_q <= 1'b1;
			else if (sync_count_point_i || !ldr[`BIT_AGC_HOLD])
				hold_q <= 1'b0;
			agc_hold_o <= hold_q;
			sample_clock_source_o <= tm1[`BIT_SAMPLE_SRC];
			probe_mux_select_o <= tm1[5:3];
			survival_bypass_o <= tm1[`BIT_BYPASS] & read_gate_i;
			precoder_bypass_o <= tm1[`BIT_BYPASS] & write_gate_i;
			byte_clock_restart_o <= tm2[`BIT_RESYNC] & (rg_rise | wg_rise);
			sync_need_both_o <= tm2[`BIT_DUAL_MATCH];
			parity_monitor_pin_o <= mon;
			ref_prescale_o <= bank_q[IDX_N][`BIT_PRESCALE];
			// one byte clock mark at first count point of a read
			if (!read_gate_i) begin
				scan_mark_q <= 1'b0;
				scan_done_q <= 1'b0;
			end else if (dr[`BIT_SCAN_START] && sync_count_point_i && !scan_done_q) begin
				scan_mark_q <= 1'b1;
				scan_done_q <= 1'b1;
			end else if (byte_clock_en_i)
				scan_mark_q <= 1'b0;
			second_nrz_line_o <= scan_mark_q;
			sync_field_count_o <= {1'b0, bank_q[IDX_SLC][7:5], 4'h0} + `SFC_STEP;
			timebase_n_o <= bank_q[IDX_N][6:0];
			timebase_m_o <= bank_q[IDX_M];
			data_rate_o <= dr[6:0];
			write_precomp_o <= bank_q[IDX_WP];
		end
	end
endmodule // read_channel_config_regs

// [tb/read_channel_config_regs_properties.sv]
/*
 * port assertions of the read channel configuration bank.
 * assumes: bound to read_channel_config_regs, single clk_i domain.
 */
`timescale 1ns/10ps
module read_channel_config_regs_properties (
	input wire clk_i,
	input wire reset_i,
	input wire serial_enable_pin_i,
	input wire serial_data_oe_o,
	input wire vco_lock_indication_i,
	input wire sync_count_point_i,
	input wire byte_clock_en_i,
	input wire timebase_sleep_o,
	input wire separator_sleep_o,
	input wire front_sleep_o,
	input wire coupler_sampled_o,
	input wire [1:0] tp_pair_select_o,
	input wire tp_third_enable_o,
	input wire tp_extra_enable_o,
	input wire scan_slice_o,
	input wire defect_flag_pin_o,
	input wire second_nrz_line_o,
	input wire [7:0] sync_field_count_o
);
	reg [2:0] start_q;
	reg [2:0] byte_q;
	// pulses go through a register inside, so allow a short look-back
	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			start_q <= 3'h0;
			byte_q <= 3'h0;
		end else begin
			start_q <= {start_q[1:0], sync_count_point_i};
			byte_q <= {byte_q[1:0], byte_clock_en_i};
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	sequence s_mark_on;
		!second_nrz_line_o ##1 second_nrz_line_o;
	endsequence
	sequence s_mark_off;
		second_nrz_line_o ##1 !second_nrz_line_o;
	endsequence
	AST_SFC_GRID: assert property (sync_field_count_o[3:0] == 4'h0
		&& sync_field_count_o != 8'h00 && sync_field_count_o <= 8'h80)
		else $error("sync field count off its grid");
	AST_SLEEP_HOLD: assert property (serial_enable_pin_i [*8]
		|-> $stable({timebase_sleep_o, separator_sleep_o, front_sleep_o}))
		else $error("sleep outputs moved inside a frame");
	AST_OE_IN_FRAME: assert property (serial_data_oe_o |-> $past(serial_enable_pin_i, 6))
		else $error("readback driven outside a frame");
	AST_THIRD_PAIR: assert property (tp_third_enable_o
		== (tp_pair_select_o == 2'b01 || tp_pair_select_o == 2'b10))
		else $error("third test pair does not follow pair select");
	AST_EXTRA_TP: assert property (tp_extra_enable_o |-> tp_pair_select_o != 2'b00)
		else $error("extra test point on with pairs off");
	AST_DEFECT_FLAG: assert property (defect_flag_pin_o |-> scan_slice_o)
		else $error("defect flag outside defect scan read");
	AST_COUPLER_LOCK: assert property ($rose(coupler_sampled_o)
		|-> $past(vco_lock_indication_i) || $past(vco_lock_indication_i, 2))
		else $error("coupler switched without vco lock");
	AST_MARK_START: assert property (s_mark_on |-> start_q != 3'h0)
		else $error("scan mark began without count point");
	AST_MARK_END: assert property (s_mark_off |-> byte_q != 3'h0)
		else $error("scan mark ended without byte clock");
endmodule // read_channel_config_regs_properties

bind read_channel_config_regs read_channel_config_regs_properties i_props (
	.clk_i, .reset_i, .serial_enable_pin_i, .serial_data_oe_o, .vco_lock_indication_i,
	.sync_count_point_i, .byte_clock_en_i, .timebase_sleep_o, .separator_sleep_o,
	.front_sleep_o, .coupler_sampled_o, .tp_pair_select_o, .tp_third_enable_o,
	.tp_extra_enable_o, .scan_slice_o, .defect_flag_pin_o, .second_nrz_line_o,
	.sync_field_count_o);

// [tb/serial_host_model.sv]
/*
 * host firmware model driving the three-wire serial port.
 * assumes clk_i is the core clock; serial clock half period is 8 clk_i.
 */
`timescale 1ns/10ps
module serial_host_model (
	input wire clk_i,
	input wire sdo_i,
	input wire sdo_oe_i,
	output reg sen_o,
	output reg sck_o,
	output reg sdi_o
);
	initial begin
		sen_o = 1'b0;
		sck_o = 1'b0;
		sdi_o = 1'b0;
	end
	task automatic xfer(input [7:0] a, input [7:0] d, output [7:0] q);
		reg [15:0] w;
		integer i;
		begin
			w = {a, d};
			q = 8'h00;
			@(posedge clk_i);
			#1 sen_o = 1'b1;
			for (i = 15; i >= 0; i = i - 1) begin
				sdi_o = w[i];
				repeat (8) @(posedge clk_i);
				// undriven readback must never pass as a good bit
				#1 if (i < 8) q[i] = sdo_oe_i ? sdo_i : 1'bx;
				sck_o = 1'b1;
				repeat (8) @(posedge clk_i);
				#1 sck_o = 1'b0;
			end
			repeat (8) @(posedge clk_i);
			#1 sen_o = 1'b0;
			sdi_o = ~sdi_o;
			repeat (4) @(posedge clk_i);
			#1;
		end
	endtask
endmodule // serial_host_model

// [tb/read_channel_config_regs_tb_top.sv]
/*
 * self-checking bench of the config bank: host frames, field decodes.
 * assumes the bank, its checker and serial_host_model are compiled first.
 */
`timescale 1ns/10ps
module read_channel_config_regs_tb_top;
	localparam [119:0] reg_vals = 120'hd7ac92ffb578902aac0e93d4ed36e0;
	reg clk_i, reset_i, read_gate_i, write_gate_i, vco_lock_indication_i, sync_count_point_i;
	reg byte_clock_en_i, parity_i, framing_detect_i, error_flag_i, dropout_i;
	reg agc_timing_source_i, hiy_dynamic_i, seen, b;
	integer n_errors, n_checks, k, p;
	reg [3:0] pat;
	wire serial_enable_pin_i, serial_clock_i, serial_data_i, serial_data_o, serial_data_oe_o;
	wire timebase_sleep_o, separator_sleep_o, front_sleep_o, coupler_sampled_o;
	wire tp_third_enable_o, tp_extra_enable_o, servo_calibrate_o, asperity_detect_enable_o;
	wire group_delay_sign_o, scan_slice_o, defect_flag_pin_o, precoder_zero_o;
	wire sample_clock_source_o, survival_bypass_o, precoder_bypass_o, byte_clock_restart_o;
	wire sync_need_both_o, parity_monitor_pin_o, ref_prescale_o, second_nrz_line_o;
	wire tp_extra_code_o, agc_hold_o;
	wire [1:0] analog_probe_select_o, tp_pair_select_o, servo_boost_o;
	wire [6:0] data_cutoff_o, servo_cutoff_o, data_boost_o, timebase_n_o, data_rate_o;
	wire [4:0] group_delay_mag_o;
	wire [3:0] target_neg_o, target_pos_o;
	wire [5:0] data_qual_level_o;
	wire [2:0] probe_mux_select_o;
	wire [7:0] sync_field_count_o, timebase_m_o, write_precomp_o;

	read_channel_config_regs i_dut (.clk_i, .reset_i, .serial_enable_pin_i, .serial_clock_i,
		.serial_data_i, .serial_data_o, .serial_data_oe_o, .read_gate_i, .write_gate_i,
		.vco_lock_indication_i, .sync_count_point_i, .byte_clock_en_i, .parity_i,
		.framing_detect_i, .error_flag_i, .dropout_i, .agc_timing_source_i, .hiy_dynamic_i,
		.timebase_sleep_o, .separator_sleep_o, .front_sleep_o, .analog_probe_select_o,
		.coupler_sampled_o, .tp_pair_select_o, .tp_third_enable_o, .tp_extra_enable_o,
		.tp_extra_code_o, .data_cutoff_o, .servo_cutoff_o, .servo_calibrate_o,
		.asperity_detect_enable_o, .data_boost_o, .servo_boost_o, .group_delay_sign_o,
		.group_delay_mag_o, .target_neg_o, .target_pos_o, .data_qual_level_o, .scan_slice_o,
		.defect_flag_pin_o, .precoder_zero_o, .agc_hold_o, .sample_clock_source_o,
		.probe_mux_select_o, .survival_bypass_o, .precoder_bypass_o, .byte_clock_restart_o,
		.sync_need_both_o, .parity_monitor_pin_o, .ref_prescale_o, .second_nrz_line_o,
		.sync_field_count_o, .timebase_n_o, .timebase_m_o, .data_rate_o, .write_precomp_o);

	serial_host_model i_host (.clk_i, .sdo_i(serial_data_o), .sdo_oe_i(serial_data_oe_o),
		.sen_o(serial_enable_pin_i), .sck_o(serial_clock_i), .sdi_o(serial_data_i));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task tick(input integer n);
		begin
			repeat (n) @(posedge clk_i);
			#1;
		end
	endtask

	task chk(input [15:0] g, input [15:0] e);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				n_errors = n_errors + 1;
				$display("Error at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask

	task wr(input [7:0] a, input [7:0] d);
		reg [7:0] q;
		begin
			i_host.xfer(a, d, q);
		end
	endtask

	task rd(input [7:0] a, input [7:0] e);
		reg [7:0] q;
		begin
			i_host.xfer(a | 8'h01, 8'h00, q);
			chk(q, e);
		end
	endtask

	task give_verdict;
		begin
			$display("checks %0d errors %0d", n_checks, n_errors);
			if (n_errors == 0 && n_checks > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask

	initial begin
		repeat (100000) @(posedge clk_i);
		n_errors = n_errors + 1;
		give_verdict;
	end

	initial begin
		n_errors = 0;
		n_checks = 0;
		reset_i = 1'b1;
		{read_gate_i, write_gate_i, vco_lock_indication_i, sync_count_point_i} = 4'h0;
		{byte_clock_en_i, parity_i, framing_detect_i, error_flag_i, dropout_i} = 5'h00;
		{agc_timing_source_i, hiy_dynamic_i} = 2'b10;
		repeat (16) @(posedge clk_i);
		#1 reset_i = 1'b0;
		tick(3);
		chk(sync_field_count_o, 16'h10);
		for (k = 0; k < 15; k = k + 1)
			wr({k[3:0], 4'h4}, reg_vals[119 - 8 * k -: 8]);
		wr(8'h08, 8'h5a);
		rd(8'h08, 8'h00);
		for (k = 0; k < 15; k = k + 1)
			rd({k[3:0], 4'h4}, reg_vals[119 - 8 * k -: 8]);
		chk({timebase_sleep_o, separator_sleep_o, front_sleep_o}, 3'h7);
		chk({analog_probe_select_o, tp_pair_select_o, tp_third_enable_o}, 5'h0e);
		chk(data_cutoff_o, 8'h2c);
		chk({servo_calibrate_o, servo_cutoff_o}, 8'h92);
		chk({asperity_detect_enable_o, data_boost_o}, 8'hff);
		chk({servo_boost_o, group_delay_sign_o, group_delay_mag_o}, 8'hb5);
		chk({target_neg_o, target_pos_o}, 8'h78);
		chk(data_qual_level_o, 8'h10);
		chk({sample_clock_source_o, probe_mux_select_o}, 4'hd);
		chk(sync_need_both_o, 1'b1);
		chk({ref_prescale_o, timebase_n_o}, 8'h93);
		chk({timebase_m_o, write_precomp_o}, 16'hd436);
		chk({data_rate_o, sync_field_count_o}, 16'h6d80);
		$display("end of register test");
		read_gate_i = 1'b1;
		dropout_i = 1'b1;
		seen = 1'b0;
		repeat (6) begin
			tick(1);
			seen = seen | byte_clock_restart_o;
		end
		chk(seen, 1'b1);
		chk({scan_slice_o, defect_flag_pin_o, survival_bypass_o, precoder_zero_o,
			precoder_bypass_o}, 5'h1c);
		b = second_nrz_line_o;
		sync_count_point_i = 1'b1;
		tick(1);
		sync_count_point_i = 1'b0;
		tick(3);
		chk(second_nrz_line_o, !b);
		byte_clock_en_i = 1'b1;
		tick(1);
		byte_clock_en_i = 1'b0;
		tick(3);
		chk(second_nrz_line_o, b);
		{read_gate_i, dropout_i, write_gate_i} = 3'b001;
		tick(6);
		chk({scan_slice_o, survival_bypass_o, precoder_zero_o, precoder_bypass_o}, 4'h3);
		write_gate_i = 1'b0;
		wr(8'h64, 8'h50);
		read_gate_i = 1'b1;
		tick(2);
		read_gate_i = 1'b0;
		tick(3);
		chk(agc_hold_o, 1'b1);
		sync_count_point_i = 1'b1;
		tick(1);
		sync_count_point_i = 1'b0;
		tick(3);
		chk(agc_hold_o, 1'b0);
		$display("end of gate test");
		for (k = 0; k < 4; k = k + 1) begin
			wr(8'h94, {6'h03, k[1:0]});
			for (p = 0; p < 2; p = p + 1) begin
				pat = p ? 4'h9 : 4'h6;
				{error_flag_i, vco_lock_indication_i, framing_detect_i, parity_i} = pat;
				tick(4);
				chk(parity_monitor_pin_o, pat[k]);
			end
		end
		vco_lock_indication_i = 1'b1;
		tick(4);
		chk(coupler_sampled_o, 1'b1);
		fork
			wr(8'h04, 8'h08);
			begin
				tick(260);
				chk({timebase_sleep_o, separator_sleep_o, front_sleep_o}, 3'h7);
			end
		join
		tick(8);
		chk({timebase_sleep_o, separator_sleep_o, front_sleep_o, coupler_sampled_o}, 4'h0);
		$display("end of monitor and power test");
		for (k = 0; k < 4; k = k + 1) begin
			wr(8'h04, {k[1:0], k[1:0], 4'h0});
			tick(8);
			chk({analog_probe_select_o, tp_pair_select_o, tp_third_enable_o, tp_extra_enable_o,
				tp_extra_code_o}, {k[1:0], k[1:0], k[0] ^ k[1], k != 0, k[1]});
		end
		hiy_dynamic_i = 1'b1;
		tick(4);
		chk(tp_extra_enable_o, 1'b0);
		{agc_timing_source_i, hiy_dynamic_i} = 2'b00;
		tick(4);
		chk(tp_extra_enable_o, 1'b0);
		agc_timing_source_i = 1'b1;
		wr(8'h14, 8'h2c);
		tick(8);
		chk({tp_pair_select_o, tp_third_enable_o, tp_extra_enable_o}, 4'h0);
		$display("end of test point test");
		for (k = 0; k < 8; k = k + 1) begin
			wr(8'he4, {k[2:0], 5'h00});
			tick(4);
			chk(sync_field_count_o, (k + 1) * 16);
		end
		$display("end of sync field test");
		give_verdict;
	end
endmodule // read_channel_config_regs_tb_top
